// ---- src/capture_pkg.sv ----
// capture_pkg: register map, field positions, reset values and
// link-domain state type for the raw capture channel.
// assumes a 32-bit apb slave decoding a 12-bit byte address.
package capture_pkg;

  ////////////////////////////////////////////////////////////////////
  // bus widths
  localparam int addr_width = 12;
  localparam int data_width = 32;
  localparam int pixel_bus_width = 20;
  localparam int pixel_width = 10;
  localparam int store_addr_width = 8;
  localparam int blank_width = 12;
  localparam int count_width = 24;

  ////////////////////////////////////////////////////////////////////
  // register offsets (byte addresses)
  localparam logic [11:0] control_offset = 12'h000;
  localparam logic [11:0] start_sync_offset = 12'h004;
  localparam logic [11:0] size_offset = 12'h008;
  localparam logic [11:0] status_offset = 12'h00c;
  // sample store window 0x400..0x7fc, one sample per word
  localparam logic [1:0] store_window = 2'h1;

  ////////////////////////////////////////////////////////////////////
  // control register fields
  localparam int port_on_bit = 0;
  localparam int word_10_bit = 1;
  localparam logic [31:0] control_write_mask = 32'h0000_0003;

  // capture_field1_start_sync fields
  localparam int line_begin_msb = 27;
  localparam int line_begin_lsb = 16;
  localparam int startup_sync_bit = 15;
  localparam int vblank_len_msb = 11;
  localparam int vblank_len_lsb = 0;
  // reserved 31:28 and 14:12 held at zero
  localparam logic [31:0] start_sync_write_mask = 32'h0fff_8fff;

  // size register fields
  localparam int size_low_msb = 11;
  localparam int size_low_lsb = 0;
  localparam int size_high_msb = 23;
  localparam int size_high_lsb = 12;
  localparam logic [31:0] size_write_mask = 32'h00ff_ffff;

  // status register fields
  localparam int active_bit = 0;
  localparam int synced_bit = 1;
  localparam int done_bit = 2;

  ////////////////////////////////////////////////////////////////////
  // reset values
  localparam logic [31:0] control_reset = 32'h0000_0000;
  localparam logic [31:0] start_sync_reset = 32'h0000_0000;
  localparam logic [31:0] size_reset = 32'h0000_0000;

  // blanking intervals that must pass before storing starts
  localparam logic [1:0] blanks_needed = 2'h2;

  ////////////////////////////////////////////////////////////////////
  // link-domain capture sequence
  typedef enum logic [1:0] {
    link_idle,
    link_hunt,
    link_capture,
    link_done
  } link_state_type;

endpackage

// ---- src/level_sync.sv ----
// level_sync: two-flop synchroniser for a group of level signals.
// assumes each bit is an independent quasi-static level.
`timescale 1ns/100ps
`default_nettype none

module level_sync #(
  parameter int width = 1
) (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic [width-1:0] d,
  output logic [width-1:0] q
);

  logic [width-1:0] meta;

  // first stage feeds only the second
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      meta <= '0;
      q <= '0;
    end else begin
      meta <= d;
      q <= meta;
    end
  end

endmodule

`default_nettype wire

// ---- src/sample_store.sv ----
// sample_store: dual-clock sample memory, write on the link clock,
// registered read on the bus clock.
// assumes reads of a word being written may return either value.
`timescale 1ns/100ps
`default_nettype none

module sample_store (
  input wire logic write_clk,
  input wire logic write_en,
  input wire logic [capture_pkg::store_addr_width-1:0] write_addr,
  input wire logic [capture_pkg::pixel_width-1:0] write_data,
  input wire logic read_clk,
  input wire logic [capture_pkg::store_addr_width-1:0] read_addr,
  output logic [capture_pkg::pixel_width-1:0] read_data
);
  import capture_pkg::*;

  logic [pixel_width-1:0] mem [0:(1<<store_addr_width)-1];

  // write port
  always_ff @(posedge write_clk) begin
    if (write_en) begin
      mem[write_addr] <= write_data;
    end
  end

  // read port, data from a register
  always_ff @(posedge read_clk) begin
    read_data <= mem[read_addr];
  end

endmodule

`default_nettype wire

// ---- src/raw_capture_channel.sv ----
// raw_capture_channel: apb register file plus a raw pixel capture
// path on the source pixel clock with startup frame alignment.
// assumes the source drives pixels and qualifier from its own clock,
// and software changes configuration only while the port is off.
`timescale 1ns/100ps
`default_nettype none

module raw_capture_channel (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [capture_pkg::addr_width-1:0] paddr,
  input wire logic [capture_pkg::data_width-1:0] pwdata,
  output logic pready,
  output logic [capture_pkg::data_width-1:0] prdata,
  output logic pslverr,
  input wire logic source_pixel_clock_in,
  input wire logic sample_qualifier_in,
  input wire logic [capture_pkg::pixel_bus_width-1:0] pixel_bus_in
);
  import capture_pkg::*;

  ////////////////////////////////////////////////////////////////////
  // declarations, bus domain

  logic access_wait;
  logic [31:0] capture_channel_control;
  logic [31:0] capture_field1_start_sync;
  logic [31:0] size_stop;
  logic [2:0] status_bus;
  logic [pixel_width-1:0] store_read_data;
  logic [31:0] read_word;

  wire logic access = psel & penable;
  wire logic take = access & access_wait;
  wire logic load_read = access & ~access_wait & ~pwrite;
  wire logic hit_control = paddr == control_offset;
  wire logic hit_start = paddr == start_sync_offset;
  wire logic hit_size = paddr == size_offset;
  wire logic hit_status = paddr == status_offset;
  wire logic hit_store =
    (paddr[11:10] == store_window) & (paddr[1:0] == 2'h0);
  wire logic mapped =
    hit_control | hit_start | hit_size | hit_status | hit_store;
  wire logic write_take = take & pwrite;
  wire logic capture_port_on = capture_channel_control[port_on_bit];
  wire logic config_open = ~capture_port_on;

  ////////////////////////////////////////////////////////////////////
  // declarations, link domain

  link_state_type state;
  link_state_type next_state;
  logic link_reset_n;
  logic port_on_link;
  logic qual_q;
  logic [pixel_bus_width-1:0] pixel_q;
  logic [blank_width-1:0] blank_cnt;
  logic armed;
  logic [1:0] blanks_seen;
  logic [count_width-1:0] sample_cnt;
  logic [2:0] status_link;

  ////////////////////////////////////////////////////////////////////
  // apb handshake

  // one wait state per transfer, read data from a register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      access_wait <= 1'b0;
    end else begin
      access_wait <= access & ~access_wait;
    end
  end

  // completion and error flag
  assign pready = take;
  assign pslverr = take & ~mapped;

  ////////////////////////////////////////////////////////////////////
  // register writes

  // control: port enable and word size
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      capture_channel_control <= control_reset;
    end else if (write_take & hit_control) begin
      capture_channel_control <= pwdata & control_write_mask;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      capture_field1_start_sync <= start_sync_reset;
    end else if (write_take & hit_start & config_open) begin
      capture_field1_start_sync <= pwdata & start_sync_write_mask;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      size_stop <= size_reset;
    end else if (write_take & hit_size & config_open) begin
      size_stop <= pwdata & size_write_mask;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // register reads

  // read selection
  always_comb begin
    read_word = 32'h0000_0000;
    if (hit_control) begin
      read_word = capture_channel_control;
    end else if (hit_start) begin
      read_word = capture_field1_start_sync;
    end else if (hit_size) begin
      read_word = size_stop;
    end else if (hit_status) begin
      read_word = {29'h0000_0000, status_bus};
    end else if (hit_store) begin
      read_word = {22'h00_0000, store_read_data};
    end
  end

  // read data register, loaded in the first access cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
    end else if (load_read) begin
      prdata <= read_word;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // crossings

  // link reset: asynchronous assert, synchronous release
  level_sync #(.width(1)) u_link_reset (
    .clk(source_pixel_clock_in),
    .reset_n(presetn),
    .d(1'b1),
    .q(link_reset_n)
  );

  // port enable level into the link domain
  level_sync #(.width(1)) u_port_on (
    .clk(source_pixel_clock_in),
    .reset_n(link_reset_n),
    .d(capture_port_on),
    .q(port_on_link)
  );

  // status levels back to the bus domain
  level_sync #(.width(3)) u_status (
    .clk(pclk),
    .reset_n(presetn),
    .d(status_link),
    .q(status_bus)
  );

  ////////////////////////////////////////////////////////////////////
  // link-side configuration view (start and size static while the port is on, word size not)

  wire logic sync_on = capture_field1_start_sync[startup_sync_bit];
  wire logic [blank_width-1:0] vblank_len =
    capture_field1_start_sync[vblank_len_msb:vblank_len_lsb];
  wire logic [count_width-1:0] size_target = {
    size_stop[size_high_msb:size_high_lsb],
    size_stop[size_low_msb:size_low_lsb]
  };
  wire logic word_10 = capture_channel_control[word_10_bit];

  ////////////////////////////////////////////////////////////////////
  // pixel input stage

  // pins registered on the source clock
  always_ff @(posedge source_pixel_clock_in or negedge link_reset_n) begin
    if (!link_reset_n) begin
      qual_q <= 1'b0;
      pixel_q <= '0;
    end else begin
      qual_q <= sample_qualifier_in;
      pixel_q <= pixel_bus_in;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // blanking detector

  wire logic [blank_width:0] low_run = 13'({1'b0, blank_cnt} + 13'h001);
  wire logic blank_hit =
    ~qual_q & armed & (low_run >= {1'b0, vblank_len});

  // count low cycles, restart on high
  always_ff @(posedge source_pixel_clock_in or negedge link_reset_n) begin
    if (!link_reset_n) begin
      blank_cnt <= '0;
      armed <= 1'b1;
    end else if (state == link_idle || qual_q) begin
      blank_cnt <= '0;
      armed <= 1'b1;
    end else begin
      if (blank_hit) begin
        armed <= 1'b0;
      end
      if (blank_cnt != 12'hfff) begin
        blank_cnt <= 12'(blank_cnt + 12'h001);
      end
    end
  end

  // blanks found since the enable rose
  always_ff @(posedge source_pixel_clock_in or negedge link_reset_n) begin
    if (!link_reset_n) begin
      blanks_seen <= 2'h0;
    end else if (state != link_hunt) begin
      blanks_seen <= 2'h0;
    end else if (blank_hit) begin
      blanks_seen <= 2'(blanks_seen + 2'h1);
    end
  end

  ////////////////////////////////////////////////////////////////////
  // capture sequence

  wire logic store = (state == link_capture) & port_on_link & qual_q;
  wire logic last_sample =
    24'(sample_cnt + 24'h00_0001) == size_target;
  wire logic second_blank =
    blank_hit & (2'(blanks_seen + 2'h1) == blanks_needed);

  always_comb begin
    next_state = state;
    unique case (state)
      link_idle: begin
        if (port_on_link) begin
          next_state = sync_on ? link_hunt : link_capture;
        end
      end
      link_hunt: begin
        if (!port_on_link) begin
          next_state = link_idle;
        end else if (second_blank) begin
          next_state = link_capture;
        end
      end
      link_capture: begin
        if (!port_on_link) begin
          next_state = link_idle;
        end else if (store && last_sample) begin
          next_state = link_done;
        end
      end
      link_done: begin
        if (!port_on_link) begin
          next_state = link_idle;
        end
      end
    endcase
  end

  // state register and status levels
  always_ff @(posedge source_pixel_clock_in or negedge link_reset_n) begin
    if (!link_reset_n) begin
      state <= link_idle;
      status_link <= 3'h0;
    end else begin
      state <= next_state;
      status_link[active_bit] <= next_state != link_idle;
      status_link[synced_bit] <= (next_state == link_capture) ||
                                 (next_state == link_done);
      status_link[done_bit] <= next_state == link_done;
    end
  end

  // sample count toward the size target
  always_ff @(posedge source_pixel_clock_in or negedge link_reset_n) begin
    if (!link_reset_n) begin
      sample_cnt <= '0;
    end else if (state == link_idle) begin
      sample_cnt <= '0;
    end else if (store) begin
      sample_cnt <= 24'(sample_cnt + 24'h00_0001);
    end
  end

  ////////////////////////////////////////////////////////////////////
  // sample storage

  wire logic [pixel_width-1:0] sample_word =
    word_10 ? pixel_q[9:0] : {2'h0, pixel_q[7:0]};

  // capture memory, read over the bus window
  sample_store u_store (
    .write_clk(source_pixel_clock_in),
    .write_en(store),
    .write_addr(sample_cnt[store_addr_width-1:0]),
    .write_data(sample_word),
    .read_clk(pclk),
    .read_addr(paddr[store_addr_width+1:2]),
    .read_data(store_read_data)
  );

endmodule

`default_nettype wire

// ---- bench/raw_capture_properties.sv ----
// raw_capture_properties: apb timing and read-data checks.
// assumes it is bound to raw_capture_channel, all on pclk.
`timescale 1ns/100ps
`default_nettype none

module raw_capture_properties (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [capture_pkg::addr_width-1:0] paddr,
  input wire logic pready,
  input wire logic [capture_pkg::data_width-1:0] prdata,
  input wire logic pslverr
);
  import capture_pkg::*;
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);

  ////////////////////////////////////////
  // bus phases and completed reads
  sequence setup_s;
    psel && !penable;
  endsequence
  sequence access_s;
    psel && penable;
  endsequence
  wire logic rd_end = pready && psel && penable && !pwrite;

  ////////////////////////////////////////
  // handshake timing
  AST_ONE_WAIT: assert property (
    setup_s ##1 access_s |-> !pready ##1 pready)
    else $error("pready not after one wait");
  AST_READY_PULSE: assert property (
    pready |=> !pready)
    else $error("pready longer than a cycle");
  AST_ERR_WITH_READY: assert property (
    pslverr |-> pready)
    else $error("pslverr without pready");
  AST_PRDATA_HOLD: assert property (
    $changed(prdata) |-> $past(psel && penable && !pwrite))
    else $error("prdata moved outside a read");

  // decoded contents
  AST_RSVD_ZERO: assert property (
    rd_end && paddr == start_sync_offset
    |-> prdata[31:28] == 4'h0 && prdata[14:12] == 3'h0)
    else $error("reserved start bits not zero");
  AST_STORE_WIDTH: assert property (
    rd_end && paddr[11:10] == store_window |-> prdata[31:10] == 22'h0)
    else $error("sample wider than ten bits");
  AST_UNMAPPED: assert property (
    pready && paddr == 12'h010 |-> pslverr)
    else $error("unmapped access not refused");
  AST_MAPPED_OK: assert property (
    pready && paddr == start_sync_offset |-> !pslverr)
    else $error("mapped access refused");
  AST_ERR_READ_ZERO: assert property (
    rd_end && pslverr |-> prdata == 32'h0000_0000)
    else $error("refused read returned data");
endmodule
`default_nettype wire

// ---- bench/sensor_model.sv ----
// sensor_model: image source, free pixel clock, line-valid framing.
// assumes hold and base change only while the source is parked.
`timescale 1ns/100ps
`default_nettype none

module sensor_model #(
  parameter int width = 4,
  parameter int hblank = 3,
  parameter int lines = 3,
  parameter int vblank = 12
) (
  input wire logic hold,
  input wire logic [9:0] base,
  output logic clk,
  output logic qual,
  output logic [19:0] pix
);
  localparam int slot = width + hblank;
  localparam int period = lines * slot + vblank;
  int t = 0;
  wire logic on_line = !hold && t < lines * slot && t % slot < width;
  wire logic [9:0] index = 10'(t / slot * width + t % slot);

  // pixel clock runs free so low runs can be counted
  initial begin
    clk = 1'h0;
    #1.3;
    forever #3 clk = ~clk;
  end

  always @(posedge clk) begin
    t <= hold ? 0 : (t + 1) % period;
    qual <= on_line;
    pix[19:10] <= 10'($urandom);
    pix[9:0] <= on_line ? base + index : ~pix[9:0];
  end
endmodule
`default_nettype wire

// ---- bench/tb_top.sv ----
// tb_top: apb master, sensor model and read scoreboard.
// assumes capture_pkg, the design and sensor_model are compiled.
`timescale 1ns/100ps
`default_nettype none

module tb_top;
  import capture_pkg::*;
  localparam int px = 12;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata;
  logic hold, lclk, qual;
  logic [9:0] base;
  logic [19:0] pix;
  logic [33:0] want;
  logic [33:0] want_q[$];
  int failures, checks_done;

  raw_capture_channel dut (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .pready(pready), .prdata(prdata), .pslverr(pslverr),
    .source_pixel_clock_in(lclk), .sample_qualifier_in(qual),
    .pixel_bus_in(pix));
  sensor_model src (.hold(hold), .base(base), .clk(lclk), .qual(qual),
    .pix(pix));

  initial begin
    pclk = 1'h0;
    forever #5 pclk = ~pclk;
  end

  ////////////////////////////////////////
  // compare and verdict
  task automatic check(input logic [32:0] seen, input logic [32:0] exp);
    checks_done++;
    if (seen !== exp) begin
      failures++;
      $display("BAD %0t: saw %h want %h", $time, seen, exp);
    end
  endtask

  task automatic report_and_stop;
    $display("checks %0d failures %0d", checks_done, failures);
    if (failures == 0 && checks_done > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  // apb transfer, held until pready
  task automatic xfer(input logic w, input logic [11:0] a,
                      input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'h1;
    penable <= 1'h0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'h1;
    do @(posedge pclk); while (pready !== 1'h1);
    psel <= 1'h0;
    penable <= 1'h0;
  endtask

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    xfer(1'h1, a, d);
  endtask

  // top bit of the note marks a read not compared
  task automatic rd(input logic [11:0] a, input logic [33:0] e);
    want_q.push_back(e);
    xfer(1'h0, a, 32'h0);
  endtask

  // one capture: park source, program, enable, release source
  task automatic run(input logic sync, input logic ten);
    logic [31:0] cfg;
    logic [9:0] v;
    hold <= 1'h1;
    // clear enable before a new alignment
    wr(control_offset, 32'h0);
    base <= 10'($urandom);
    cfg = $urandom;
    cfg[15] = sync;
    // length between line and frame blank, line begin random
    cfg[11:0] = 12'h005;
    wr(start_sync_offset, cfg);
    wr(size_offset, 32'(px));
    wr(control_offset, {30'h0, ten, 1'h1});
    repeat (8) @(posedge pclk);
    hold <= 1'h0;
    repeat (22) @(posedge pclk);
    rd(status_offset, 34'h2_0000_0000);
    check({32'h0, prdata[done_bit]}, {32'h0, !sync});
    do rd(status_offset, 34'h2_0000_0000);
    while (prdata[done_bit] !== 1'h1);
    for (int i = 0; i < px; i++) begin
      v = base + 10'(i);
      rd(12'h400 + 12'(4 * i), {24'h0, ten ? v : {2'h0, v[7:0]}});
    end
    // start writes dropped while the port is on
    wr(start_sync_offset, ~cfg);
    cfg[31:28] = 4'h0;
    cfg[14:12] = 3'h0;
    rd(start_sync_offset, {2'h0, cfg});
  endtask

  // scoreboard: oldest note against each completed read
  always @(posedge pclk) begin
    if (psel && penable && pready === 1'h1 && !pwrite) begin
      want = want_q.pop_front();
      if (!want[33])
        check({pslverr, prdata}, want[32:0]);
    end
  end

  // watchdog
  initial begin
    repeat (20000) @(posedge pclk);
    failures++;
    report_and_stop;
  end

  initial begin
    logic [31:0] v;
    void'($urandom(32'he583));
    failures = 0;
    checks_done = 0;
    presetn = 1'h0;
    psel = 1'h0;
    penable = 1'h0;
    pwrite = 1'h0;
    paddr = 12'h0;
    pwdata = 32'h0;
    hold = 1'h1;
    base = 10'h0;
    repeat (5) @(posedge pclk);
    presetn <= 1'h1;
    rd(control_offset, 34'h0);
    rd(start_sync_offset, 34'h0);
    rd(size_offset, 34'h0);
    rd(12'h010, 34'h1_0000_0000);
    rd(12'h402, 34'h1_0000_0000);
    repeat (6) begin
      v = $urandom;
      wr(start_sync_offset, v);
      v[31:28] = 4'h0;
      v[14:12] = 3'h0;
      rd(start_sync_offset, {2'h0, v});
    end
    run(1'h1, 1'h1);
    run(1'h0, 1'h0);
    run(1'h0, 1'h1);
    run(1'h1, 1'h0);
    report_and_stop;
  end
endmodule

bind raw_capture_channel raw_capture_properties chk (.pclk(pclk),
  .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pready(pready), .prdata(prdata), .pslverr(pslverr));
`default_nettype wire
